//--- include/sbd_pkg.sv
// Shared constants and types for the sequential binary divider.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`default_nettype none

package sbd_pkg;

   // Default operand widths
   localparam int SBD_WIDTH = 8;
   localparam int SBD_EXP_W = 8;

   // Bus geometry
   localparam int SBD_ADDR_W = 5;
   localparam int SBD_DATA_W = 32;

   // Register byte offsets
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_CTRL   = 5'h00;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_OPER   = 5'h04;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_EXP    = 5'h08;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_STATUS = 5'h0c;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_QUOT   = 5'h10;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_REM    = 5'h14;
   localparam logic [SBD_ADDR_W-1:0] SBD_OFS_FLOAT  = 5'h18;

   // Field widths and positions
   localparam int SBD_CTRL_W      = 5;
   localparam int SBD_EXP_Y_POS   = 8;
   localparam int SBD_ST_COUNT_W  = 8;

   // Rounding modes of the shifted-in dividend bits
   localparam logic [1:0] SBD_RND_NONE      = 2'h0;
   localparam logic [1:0] SBD_RND_ONE_ZEROS = 2'h1;
   localparam logic [1:0] SBD_RND_ZERO_ONES = 2'h2;

   // Control word: bit 0 load, 1 float, 3:2 rounding, 4 serial source
   typedef struct packed {
      logic       serial_src;
      logic [1:0] round_mode;
      logic       float_en;
      logic       load;
   } sbd_ctrl_t;

   // Status word: step count in 15:8, flags in 3:0
   typedef struct packed {
      logic [SBD_ST_COUNT_W-1:0] step_count;
      logic [3:0]                zero_pad;
      logic                      rem_valid;
      logic                      div_by_zero;
      logic                      done;
      logic                      busy;
   } sbd_status_t;

   // Reset values
   localparam sbd_ctrl_t SBD_CTRL_RST = '0;

   // Sequencer states
   typedef enum logic [1:0] {
      SBD_IDLE,
      SBD_JOINT,
      SBD_DALIGN,
      SBD_DIVIDE
   } sbd_state_t;

endpackage

`default_nettype wire

//--- rtl/sbd_stage.sv
// Subtractor and divisor leading-zero encoder of the divider.
// Purely combinational; the sequencer registers its results.
`default_nettype none
`timescale 1ns/100ps

module sbd_stage
   import sbd_pkg::*;
#(
   parameter int W  = SBD_WIDTH,
   parameter int CW = 4
)(
   // Operands
   input  wire logic [W:0]    x,
   input  wire logic [W-1:0]  y,
   // Results
   output logic      [W-1:0]  diff,
   output logic               ge,
   output logic               y_zero,
   output logic      [CW-1:0] preset
);

   logic [W+1:0]  sum;
   logic [CW-1:0] lz;

   // Inverted divisor plus forced carry in
   assign sum    = {1'b0, x} + {2'b11, ~y} + (W+2)'(1);
   assign ge     = ~sum[W+1];
   assign diff   = sum[W-1:0];
   assign y_zero = (y == '0);

   // Highest set divisor bit wins
   always_comb begin
      lz = CW'(W);
      for (int i = 0; i < W; i++) begin
         if (y[i]) begin
            lz = CW'(W - 1 - i);
         end
      end
   end

   assign preset = CW'(W - 1) - lz;

endmodule

`default_nettype wire

//--- rtl/sbd_divider.sv
// Sequential shift and subtract binary divider with Avalon-MM registers.
// Assumes a same-clock host issuing requests and serial operand bits.
//
// Contract
// - Load captures operands, clears counter and quotient, sets both flops.
// - Shift dividend and divisor together until either top bit is one.
// - Preset counter from divisor leading zeros, then clear completion flop.
// - Operands are 8 bits; quotient is 16 bits, point in the middle.
// - Divisor alone shifts until its top bit is one; counter holds.
// - Each step subtracts; a smaller dividend is merely shifted.
// - Otherwise load shifted difference and set the addressed quotient bit.
// - Counter increments every step; loop ends at terminal count 15.
// - Completion flop sets at loop end; quotient then valid.
// - A ninth dividend bit lets a dividend with bit 7 set shift.
// - Subtract by adding inverted divisor with carry in; drop top bit.
// - Zero divisor raises divide-by-zero and never raises completion.
// - No rounding by default; exact quotient plus remainder.
// - Optional one-then-zeros or zero-then-ones fill rounds; remainder invalid.
// - Wider variant widens data paths; counter gains one bit only.
// - Serial variant loads operands and emits quotient bits serially.
// - Float mode skips encoding, presets seven, divides at once.
// - Float mode subtracts exponents, nine-bit quotient, normalising shift.
`default_nettype none
`timescale 1ns/100ps

module sbd_divider
   import sbd_pkg::*;
#(
   parameter int W  = SBD_WIDTH,
   parameter int EW = SBD_EXP_W
)(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   // Avalon-MM slave
   input  wire logic [SBD_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [SBD_DATA_W-1:0] avs_writedata,
   output logic      [SBD_DATA_W-1:0] avs_readdata,
   output logic                       avs_waitrequest,
   // Serial operand input
   input  wire logic                  ser_valid,
   input  wire logic                  ser_dividend_bit,
   input  wire logic                  ser_divisor_bit,
   // Serial quotient output
   output logic                       q_ser_bit,
   output logic                       q_ser_valid,
   // Results
   output logic      [2*W-1:0]        quotient,
   output logic      [W:0]            remainder,
   output logic                       done,
   output logic                       div_by_zero,
   output logic                       busy
);

   localparam int             CW         = $clog2(2 * W);
   localparam logic [CW-1:0]  TC         = CW'(2 * W - 1);
   localparam logic [CW-1:0]  PRESET_FP  = CW'(W - 1);

   // Bus handshake
   logic                  ack_q;
   logic [SBD_DATA_W-1:0] rdata_q;
   wire                   req     = avs_read | avs_write;
   wire                   wr_ack  = avs_write & ack_q;
   wire                   rd_take = avs_read & ~ack_q;

   // Software visible staging registers and serial operand shift registers
   sbd_ctrl_t       ctrl_q;
   logic [W-1:0]    op_x_q;
   logic [W-1:0]    op_y_q;
   logic [EW-1:0]   exp_x_q;
   logic [EW-1:0]   exp_y_q;
   logic [W-1:0]    ser_x_q;
   logic [W-1:0]    ser_y_q;

   // Datapath and sequencer
   sbd_state_t      state_q,  state_d;
   sbd_ctrl_t       cfg_q,    cfg_d;
   logic [W:0]      x_q,      x_d;
   logic [W-1:0]    y_q,      y_d;
   logic [CW-1:0]   cnt_q,    cnt_d;
   logic [2*W-1:0]  q_q,      q_d;
   logic            cff_q,    cff_d;
   logic            align_q,  align_d;
   logic            dbz_q,    dbz_d;
   logic            first_q,  first_d;
   logic            qsb_q,    qsb_d;
   logic            qsv_q,    qsv_d;
   logic [W-1:0]    fman_q,   fman_d;
   logic [EW-1:0]   fexp_q,   fexp_d;

   // Stage results
   logic [W-1:0]    diff;
   logic            ge;
   logic            y_zero;
   logic [CW-1:0]   preset;

   // Address decode
   wire sel_ctrl   = (avs_address == SBD_OFS_CTRL);
   wire sel_oper   = (avs_address == SBD_OFS_OPER);
   wire sel_exp    = (avs_address == SBD_OFS_EXP);
   wire sel_status = (avs_address == SBD_OFS_STATUS);
   wire sel_quot   = (avs_address == SBD_OFS_QUOT);
   wire sel_rem    = (avs_address == SBD_OFS_REM);
   wire sel_float  = (avs_address == SBD_OFS_FLOAT);

   // Control write decode
   sbd_ctrl_t wr_cfg;
   assign wr_cfg = sbd_ctrl_t'(avs_writedata[SBD_CTRL_W-1:0]);

   wire load_pulse = wr_ack & sel_ctrl & wr_cfg.load;

   // Operand source for load
   wire [W-1:0] ld_x = wr_cfg.serial_src ? ser_x_q : op_x_q;
   wire [W-1:0] ld_y = wr_cfg.serial_src ? ser_y_q : op_y_q;

   // Dividend fill bit for rounding
   wire rnd_bit = (cfg_q.round_mode == SBD_RND_ONE_ZEROS) ?  first_q :
                  (cfg_q.round_mode == SBD_RND_ZERO_ONES) ? ~first_q :
                  1'b0;

   wire rem_valid = (cfg_q.round_mode == SBD_RND_NONE);

   // Quotient bit addressed by the step counter
   wire [CW-1:0]  q_idx = TC - cnt_q;
   wire [2*W-1:0] q_fin = q_q | (2*W)'(ge);
   wire           q_int = q_fin[W];

   // Status word
   sbd_status_t status_w;
   assign status_w = '{step_count:  SBD_ST_COUNT_W'(cnt_q),
                       zero_pad:    4'h0,
                       rem_valid:   rem_valid,
                       div_by_zero: dbz_q,
                       done:        done,
                       busy:        busy};

   // Read data selection; unmapped reads return zero
   wire [SBD_DATA_W-1:0] rd_mux =
      sel_ctrl   ? SBD_DATA_W'(ctrl_q)                          :
      sel_oper   ? SBD_DATA_W'({op_y_q, op_x_q})                :
      sel_exp    ? (SBD_DATA_W'(exp_y_q) << SBD_EXP_Y_POS) |
                   SBD_DATA_W'(exp_x_q)                         :
      sel_status ? SBD_DATA_W'(status_w)                        :
      sel_quot   ? SBD_DATA_W'(q_q)                             :
      sel_rem    ? SBD_DATA_W'(x_q)                             :
      sel_float  ? SBD_DATA_W'({fexp_q, fman_q})                :
      SBD_DATA_W'(0);

   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;

   sbd_stage #(
      .W  (W),
      .CW (CW)
   ) u_stage (
      .x      (x_q),
      .y      (y_q),
      .diff   (diff),
      .ge     (ge),
      .y_zero (y_zero),
      .preset (preset)
   );

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      cfg_d   = cfg_q;
      x_d     = x_q;
      y_d     = y_q;
      cnt_d   = cnt_q;
      q_d     = q_q;
      cff_d   = cff_q;
      align_d = align_q;
      dbz_d   = dbz_q;
      first_d = first_q;
      qsb_d   = qsb_q;
      qsv_d   = 1'b0;
      fman_d  = fman_q;
      fexp_d  = fexp_q;
      if (load_pulse) begin
         cfg_d   = wr_cfg;
         x_d     = {1'b0, ld_x};
         y_d     = ld_y;
         cnt_d   = '0;
         q_d     = '0;
         cff_d   = 1'b1;
         align_d = 1'b1;
         dbz_d   = 1'b0;
         first_d = 1'b1;
         fexp_d  = exp_x_q - exp_y_q;
         if (wr_cfg.float_en) begin
            cnt_d   = PRESET_FP;
            cff_d   = 1'b0;
            align_d = 1'b0;
            state_d = SBD_DIVIDE;
         end else begin
            state_d = SBD_JOINT;
         end
      end else begin
         unique case (state_q)
            SBD_IDLE: begin
            end
            SBD_JOINT: begin
               if (y_zero) begin
                  dbz_d   = 1'b1;
                  cff_d   = 1'b0;
                  align_d = 1'b0;
                  state_d = SBD_IDLE;
               end else if (x_q[W-1] | y_q[W-1]) begin
                  cnt_d   = preset;
                  cff_d   = 1'b0;
                  align_d = 1'b0;
                  state_d = y_q[W-1] ? SBD_DIVIDE : SBD_DALIGN;
               end else begin
                  x_d = {x_q[W-1:0], 1'b0};
                  y_d = {y_q[W-2:0], 1'b0};
               end
            end
            SBD_DALIGN: begin
               y_d = {y_q[W-2:0], 1'b0};
               if (y_q[W-2]) begin
                  state_d = SBD_DIVIDE;
               end
            end
            SBD_DIVIDE: begin
               if (y_zero) begin
                  dbz_d   = 1'b1;
                  state_d = SBD_IDLE;
               end else begin
                  if (ge) begin
                     x_d        = {diff, rnd_bit};
                     q_d[q_idx] = 1'b1;
                  end else begin
                     x_d = {x_q[W-1:0], rnd_bit};
                  end
                  qsb_d   = ge;
                  qsv_d   = 1'b1;
                  first_d = 1'b0;
                  if (cnt_q == TC) begin
                     cff_d   = 1'b1;
                     state_d = SBD_IDLE;
                     if (cfg_q.float_en) begin
                        fman_d = q_int ? q_fin[W:1] : q_fin[W-1:0];
                        fexp_d = fexp_q + EW'(q_int);
                     end
                  end else begin
                     cnt_d = cnt_q + CW'(1);
                  end
               end
            end
         endcase
      end
   end

   // Bus handshake: one wait state, read data registered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= req & ~ack_q;
         if (rd_take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Staging register writes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q  <= SBD_CTRL_RST;
         op_x_q  <= '0;
         op_y_q  <= '0;
         exp_x_q <= '0;
         exp_y_q <= '0;
      end else if (wr_ack) begin
         if (sel_ctrl) begin
            ctrl_q      <= wr_cfg;
            ctrl_q.load <= 1'b0;
         end
         if (sel_oper) begin
            op_x_q <= avs_writedata[W-1:0];
            op_y_q <= avs_writedata[2*W-1:W];
         end
         if (sel_exp) begin
            exp_x_q <= avs_writedata[EW-1:0];
            exp_y_q <= avs_writedata[SBD_EXP_Y_POS +: EW];
         end
      end
   end

   // Serial operand shift-in, most significant bit first
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ser_x_q <= '0;
         ser_y_q <= '0;
      end else if (ser_valid) begin
         ser_x_q <= {ser_x_q[W-2:0], ser_dividend_bit};
         ser_y_q <= {ser_y_q[W-2:0], ser_divisor_bit};
      end
   end

   // Sequencer registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= SBD_IDLE;
         cfg_q   <= SBD_CTRL_RST;
         x_q     <= '0;
         y_q     <= '0;
         cnt_q   <= '0;
         q_q     <= '0;
         cff_q   <= 1'b0;
         align_q <= 1'b0;
         dbz_q   <= 1'b0;
         first_q <= 1'b0;
         qsb_q   <= 1'b0;
         qsv_q   <= 1'b0;
         fman_q  <= '0;
         fexp_q  <= '0;
      end else begin
         state_q <= state_d;
         cfg_q   <= cfg_d;
         x_q     <= x_d;
         y_q     <= y_d;
         cnt_q   <= cnt_d;
         q_q     <= q_d;
         cff_q   <= cff_d;
         align_q <= align_d;
         dbz_q   <= dbz_d;
         first_q <= first_d;
         qsb_q   <= qsb_d;
         qsv_q   <= qsv_d;
         fman_q  <= fman_d;
         fexp_q  <= fexp_d;
      end
   end

   // Completion hidden while alignment flop is set
   assign done        = cff_q & ~align_q;
   assign div_by_zero = dbz_q;
   assign busy        = (state_q != SBD_IDLE);
   assign quotient    = q_q;
   assign remainder   = x_q;
   assign q_ser_bit   = qsb_q;
   assign q_ser_valid = qsv_q;

endmodule

`default_nettype wire

//--- sim/sbd_divider_checker.sv
// Port assertions for the sequential divider.
// Bound onto sbd_divider; one clock, reset low.
`timescale 1ns/100ps
`default_nettype none
module sbd_divider_checker
   import sbd_pkg::*;
#(
   parameter int W  = SBD_WIDTH,
   parameter int EW = SBD_EXP_W
)(
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst_b,
   // Bus
   input wire logic [SBD_ADDR_W-1:0] avs_address,
   input wire logic                  avs_write,
   input wire logic [SBD_DATA_W-1:0] avs_writedata,
   input wire logic                  avs_waitrequest,
   // Results
   input wire logic                  q_ser_valid,
   input wire logic [2*W-1:0]        quotient,
   input wire logic [W:0]            remainder,
   input wire logic                  done,
   input wire logic                  div_by_zero,
   input wire logic                  busy
);
   logic [W-1:0] dvs_q;
   logic [4:0]   steps_q;
   wire          wr_ok = avs_write & ~avs_waitrequest;
   wire          ld = wr_ok & (avs_address == SBD_OFS_CTRL)
                      & avs_writedata[0];
   wire          ld_par = ld & ~avs_writedata[4];
   wire          nz = |dvs_q;
   wire          oper_wr = wr_ok & (avs_address == SBD_OFS_OPER);

   // Last divisor written, and steps since load
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dvs_q <= '0;
         steps_q <= '0;
      end else begin
         if (oper_wr)
            dvs_q <= avs_writedata[2*W-1:W];
         steps_q <= ld ? 5'h00 : steps_q + {4'h0, q_ser_valid};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_ld_clear;
      ld |=> (!done && !div_by_zero) ##1 !done [*7];
   endproperty
   a_ld_clear: assert property (p_ld_clear)
      else $error("status not cleared by load");
   property p_ld_start;
      ld_par && nz |=> busy && quotient == '0;
   endproperty
   a_ld_start: assert property (p_ld_start)
      else $error("load did not start a clean run");
   property p_dbz_time;
      ld_par && !nz |=> ##1 div_by_zero;
   endproperty
   a_dbz_time: assert property (p_dbz_time)
      else $error("zero divisor not flagged");
   property p_dbz_nodone;
      div_by_zero |-> !done;
   endproperty
   a_dbz_nodone: assert property (p_dbz_nodone)
      else $error("done with zero divisor");
   property p_done_time;
      ld_par && nz |=> ##[8:30] done;
   endproperty
   a_done_time: assert property (p_done_time)
      else $error("done late");
   property p_hold;
      done && !ld |=> done && $stable(quotient) && $stable(remainder);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result changed before next load");
   property p_done_idle;
      done |-> !busy;
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("busy while done");
   property p_steps;
      $rose(done) |-> (steps_q + {4'h0, q_ser_valid}) inside {[9:16]};
   endproperty
   a_steps: assert property (p_steps)
      else $error("wrong number of steps");
endmodule
`default_nettype wire

//--- sim/sbd_serial_src.sv
// Host-side serial operand source for the divider.
// Same clock as the divider; shifts both operands on start.
`timescale 1ns/100ps
`default_nettype none
module sbd_serial_src
   import sbd_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Request
   input  wire logic                 start,
   input  wire logic [SBD_WIDTH-1:0] dvd,
   input  wire logic [SBD_WIDTH-1:0] dvs,
   // Serial lines
   output logic                      ser_valid,
   output logic                      ser_dividend_bit,
   output logic                      ser_divisor_bit,
   output logic                      running
);
   logic [SBD_WIDTH-1:0] a_q;
   logic [SBD_WIDTH-1:0] b_q;
   logic [3:0]           n_q;
   assign running = n_q != 4'h0;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         n_q <= 4'h0;
         ser_valid <= 1'b0;
         ser_dividend_bit <= 1'b0;
         ser_divisor_bit <= 1'b0;
      end else if (start) begin
         a_q <= dvd;
         b_q <= dvs;
         n_q <= 4'h8;
         ser_valid <= 1'b0;
      end else if (running) begin
         ser_valid <= 1'b1;
         ser_dividend_bit <= a_q[SBD_WIDTH-1];
         ser_divisor_bit <= b_q[SBD_WIDTH-1];
         a_q <= a_q << 1;
         b_q <= b_q << 1;
         n_q <= n_q - 4'h1;
      end else begin
         // Idle lines toggle so stale bits never look valid
         ser_valid <= 1'b0;
         ser_dividend_bit <= ~ser_dividend_bit;
         ser_divisor_bit <= ~ser_divisor_bit;
      end
   end
endmodule
`default_nettype wire

//--- sim/sbd_divider_test.sv
// Bench for sbd_divider: bus tasks, division tables, serial source.
// Checker is bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module sbd_divider_test
   import sbd_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic [SBD_ADDR_W-1:0] avs_address = '0;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [SBD_DATA_W-1:0] avs_writedata = '0;
   wire  [SBD_DATA_W-1:0] avs_readdata;
   wire                   avs_waitrequest, q_ser_bit, q_ser_valid;
   wire                   done, div_by_zero, busy, src_run;
   wire                   ser_valid, ser_dividend_bit, ser_divisor_bit;
   wire  [15:0]           quotient;
   wire  [8:0]            remainder;
   logic                  src_go = 1'b0;
   logic [7:0]            src_a = '0, src_b = '0;
   logic [15:0]           ser_acc = '0, e;
   logic [31:0]           rd;
   int                    fails = 0, total_checks = 0, cycles = 0, lat;
   logic [7:0] xs [9] = '{8'h80, 8'h01, 8'h80, 8'hff, 8'h01, 8'hc8,
                          8'h03, 8'hff, 8'h00};
   logic [7:0] ys [9] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'hff, 8'h07,
                          8'h05, 8'hff, 8'h09};

   sbd_divider sbd_divider_i (
      .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ser_valid(ser_valid),
      .ser_dividend_bit(ser_dividend_bit),
      .ser_divisor_bit(ser_divisor_bit), .q_ser_bit(q_ser_bit),
      .q_ser_valid(q_ser_valid), .quotient(quotient),
      .remainder(remainder), .done(done), .div_by_zero(div_by_zero),
      .busy(busy));
   sbd_serial_src sbd_serial_src_i (
      .core_clk(core_clk), .rst_b(rst_b), .start(src_go), .dvd(src_a),
      .dvs(src_b), .ser_valid(ser_valid),
      .ser_dividend_bit(ser_dividend_bit),
      .ser_divisor_bit(ser_divisor_bit), .running(src_run));

   always #5 core_clk = ~core_clk;

   task automatic results();
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         results();
      end
   end

   // Quotient bits as they leave the serial output
   always @(posedge core_clk) begin
      if (avs_write && !avs_waitrequest && avs_address == SBD_OFS_CTRL
          && avs_writedata[0])
         ser_acc <= '0;
      else if (q_ser_valid)
         ser_acc <= {ser_acc[14:0], q_ser_bit};
   end

   task automatic chk(input string n, input logic [31:0] s, x);
      total_checks++;
      if (s !== x) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, x, s);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic run(input logic [7:0] x, y, input logic [4:0] c);
      bus(1'b1, SBD_OFS_OPER, {16'h0, y, x});
      bus(1'b1, SBD_OFS_CTRL, {27'h0, c});
      for (lat = 0; lat < 40; lat++) begin
         @(posedge core_clk);
         if (done === 1'b1 || div_by_zero === 1'b1)
            break;
      end
   endtask

   function automatic logic [15:0] qexp(input logic [7:0] x, y);
      return {x, 8'h00} / {8'h00, y};
   endfunction

   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      bus(1'b0, SBD_OFS_STATUS, '0);
      chk("status_rst", rd, 32'h8);
      bus(1'b1, SBD_OFS_CTRL, 32'h0e);
      bus(1'b0, SBD_OFS_CTRL, '0);
      chk("ctrl", rd, 32'h0e);
      bus(1'b1, 5'h1c, 32'hffff_ffff);
      bus(1'b0, 5'h1c, '0);
      chk("unmapped", rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         run(xs[i], ys[i], 5'h01);
         e = qexp(xs[i], ys[i]);
         bus(1'b0, SBD_OFS_QUOT, '0);
         chk("quot", rd, {16'h0, e});
         chk("quot_port", quotient, e);
         chk("ser_bits", ser_acc, e);
         chk("rem_zero", remainder == 0, e * ys[i] == {xs[i], 8'h0});
         bus(1'b0, SBD_OFS_STATUS, '0);
         chk("status", rd[15:0], 16'h0f0a);
      end
      $display("test integer done");
      for (int i = 0; i < 2; i++) begin
         run(i ? 8'h05 : 8'h00, 8'h00, 5'h01);
         repeat (30) @(posedge core_clk);
         chk("dbz_done", done, 1'b0);
         bus(1'b0, SBD_OFS_STATUS, '0);
         chk("dbz_status", rd[2:0], 3'b100);
      end
      $display("test zero divisor done");
      bus(1'b1, SBD_OFS_OPER, 32'h0101);
      bus(1'b1, SBD_OFS_CTRL, 32'h01);
      run(8'hc8, 8'h07, 5'h01);
      chk("restart", quotient, qexp(8'hc8, 8'h07));
      run(8'hff, 8'hfe, 5'h01);
      bus(1'b0, SBD_OFS_REM, '0);
      chk("rem_reg", rd, 32'h4);
      run(remainder[8:1], 8'hfe, 5'h01);
      chk("rem_feed", quotient, qexp(8'h02, 8'hfe));
      $display("test restart done");
      for (int m = 1; m < 3; m++) begin
         run(8'h03, 8'h05, {1'b0, m[1:0], 2'b01});
         e = qexp(8'h03, 8'h05);
         chk("round", quotient == e || quotient == e + 1, 1'b1);
         bus(1'b0, SBD_OFS_STATUS, '0);
         chk("rem_invalid", rd[3], 1'b0);
         bus(1'b0, SBD_OFS_CTRL, '0);
         chk("ctrl_round", rd, {28'h0, m[1:0], 2'b00});
      end
      $display("test rounding done");
      bus(1'b1, SBD_OFS_EXP, 32'h0310);
      for (int i = 0; i < 2; i++) begin
         run(i ? 8'h80 : 8'hc0, i ? 8'hc0 : 8'h80, 5'h03);
         chk("float_lat", lat, 9);
         e = qexp(i ? 8'h80 : 8'hc0, i ? 8'hc0 : 8'h80);
         bus(1'b0, SBD_OFS_FLOAT, '0);
         chk("float", rd[15:0], e[8] ? {8'h0e, e[8:1]} : {8'h0d, e[7:0]});
      end
      $display("test float done");
      src_a <= 8'ha5;
      src_b <= 8'h0b;
      src_go <= 1'b1;
      @(posedge core_clk);
      src_go <= 1'b0;
      repeat (10) @(posedge core_clk);
      bus(1'b1, SBD_OFS_CTRL, 32'h11);
      @(posedge core_clk);
      for (int i = 0; i < 40 && done !== 1'b1; i++)
         @(posedge core_clk);
      @(posedge core_clk);
      chk("serial", quotient, qexp(8'ha5, 8'h0b));
      chk("serial_bits", ser_acc, qexp(8'ha5, 8'h0b));
      $display("test serial done");
      results();
   end
endmodule

bind sbd_divider sbd_divider_checker #(.W(W), .EW(EW)) chk_i (
   .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .q_ser_valid(q_ser_valid),
   .quotient(quotient), .remainder(remainder), .done(done),
   .div_by_zero(div_by_zero), .busy(busy));
`default_nettype wire
